/* tap_pkg.sv */
// Purpose: Shared constants and types for the boundary-scan test port.
// Assumes: Test clock is sampled by the 25 MHz system clock.
// Notes:   Instruction codes are arbitrary; the ID value is arbitrary.
package tap_pkg;
    localparam int         IR_WIDTH      = 4;
    localparam int         ID_WIDTH      = 32;
    localparam int         RESET_TMS_LEN = 5;
    localparam logic [3:0] IR_RESET      = 4'h1;
    localparam logic [3:0] IR_IDCODE     = 4'h1;
    localparam logic [3:0] IR_BYPASS     = 4'hf;
    // Arbitrary identification value, names no maker
    localparam logic [31:0] ID_VALUE     = 32'h0000_0001;
    localparam int         TCK_DIV       = 4;

    typedef enum logic [15:0] {
        ST_RESET     = 16'h0001,
        ST_IDLE      = 16'h0002,
        ST_SEL_DR    = 16'h0004,
        ST_CAP_DR    = 16'h0008,
        ST_SHIFT_DR  = 16'h0010,
        ST_EXIT1_DR  = 16'h0020,
        ST_PAUSE_DR  = 16'h0040,
        ST_EXIT2_DR  = 16'h0080,
        ST_UPD_DR    = 16'h0100,
        ST_SEL_IR    = 16'h0200,
        ST_CAP_IR    = 16'h0400,
        ST_SHIFT_IR  = 16'h0800,
        ST_EXIT1_IR  = 16'h1000,
        ST_PAUSE_IR  = 16'h2000,
        ST_EXIT2_IR  = 16'h4000,
        ST_UPD_IR    = 16'h8000
    } tap_state_t;

    function automatic tap_state_t tap_next(input tap_state_t s,
                                            input logic       tms);
        case (s)
            ST_RESET:    tap_next = tms ? ST_RESET   : ST_IDLE;
            ST_IDLE:     tap_next = tms ? ST_SEL_DR  : ST_IDLE;
            ST_SEL_DR:   tap_next = tms ? ST_SEL_IR  : ST_CAP_DR;
            ST_CAP_DR:   tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: tap_next = tms ? ST_UPD_DR  : ST_PAUSE_DR;
            ST_PAUSE_DR: tap_next = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: tap_next = tms ? ST_UPD_DR  : ST_SHIFT_DR;
            ST_UPD_DR:   tap_next = tms ? ST_SEL_DR  : ST_IDLE;
            ST_SEL_IR:   tap_next = tms ? ST_RESET   : ST_CAP_IR;
            ST_CAP_IR:   tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: tap_next = tms ? ST_UPD_IR  : ST_PAUSE_IR;
            ST_PAUSE_IR: tap_next = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: tap_next = tms ? ST_UPD_IR  : ST_SHIFT_IR;
            ST_UPD_IR:   tap_next = tms ? ST_SEL_DR  : ST_IDLE;
            default:     tap_next = ST_RESET;
        endcase
    endfunction : tap_next
endpackage : tap_pkg

/* tap_if.sv */
// Purpose: Four-wire test port plus optional test reset between two ends.
// Assumes: Pull-ups on data in and mode select resolved here.
// Notes:   Data out floats to high when not enabled.
`timescale 1ns/10ps
interface tap_if;
    logic tck;
    logic tms_drv;
    logic tms_oe_n;
    logic tdi_drv;
    logic tdi_oe_n;
    logic trst_n;
    logic tdo_drv;
    logic tdo_oe_n;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_active;

    // Internal pull-ups: an undriven line reads high
    assign tms        = tms_oe_n ? 1'b1 : tms_drv;
    assign tdi        = tdi_oe_n ? 1'b1 : tdi_drv;
    assign tdo        = tdo_oe_n ? 1'b1 : tdo_drv;
    assign tdo_active = ~tdo_oe_n;

    modport dev  (input tck, tms, tdi, trst_n,
                  output tdo_drv, tdo_oe_n);
    modport ctrl (output tck, tms_drv, tms_oe_n, tdi_drv, tdi_oe_n, trst_n,
                  input tdo, tdo_active);
endinterface : tap_if

/* tap_device.sv */
// Overview of operation
// - Sample mode select, data in on rise
// - Change data out only on fall; here test reset floats it at once
// - Shift data into instruction, ID, bypass
// - Drive data out only in shift states
// - Undriven data in reads high
// - Undriven mode select reads high
// - Mode select alone steers the controller
// - Test reset acts at once, unclocked; here it first passes two clk_i flops
// - Tester must reset port after power-up
// - Float FIFO outputs until port reset
// - Test reset may tie to FIFO reset
// - Unused port: clock, reset held low
//
// Purpose: Device end of the boundary-scan port.
// Assumes: Test clock is slow against clk_i and sampled by it.
// Notes:   Test reset is synchronised; it still acts with no test clock.
`timescale 1ns/10ps
module tap_device
    import tap_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    tap_if.dev        link,
    input  wire logic fifo_master_reset_n_i,
    output logic      fifo_out_float_o,
    output logic      tap_in_reset_o
);
    logic [1:0]          tck_sync;
    logic [1:0]          tms_sync;
    logic [1:0]          tdi_sync;
    logic [1:0]          trst_sync;
    logic                tck_prev;
    tap_state_t          state;
    tap_state_t          next_state;
    logic [IR_WIDTH-1:0] ir_shift;
    logic [IR_WIDTH-1:0] next_ir_shift;
    logic [IR_WIDTH-1:0] ir;
    logic [IR_WIDTH-1:0] next_ir;
    logic [ID_WIDTH-1:0] dr_shift;
    logic [ID_WIDTH-1:0] next_dr_shift;
    logic                tdo_q;
    logic                next_tdo_q;
    logic                tdo_oe_n_q;
    logic                next_tdo_oe_n_q;
    logic                was_reset;
    logic                next_was_reset;
    logic                float_q;
    logic                next_float_q;
    logic                in_reset_q;
    logic                next_in_reset_q;
    logic                rise;
    logic                fall;
    logic                tap_rst;

    // First argument high, second low: an edge between them
    function automatic logic edge_seen(input logic now_lvl,
                                       input logic old_lvl);
        edge_seen = now_lvl & ~old_lvl;
    endfunction : edge_seen

    // Every code but the identification one selects bypass
    function automatic logic id_selected(input logic [IR_WIDTH-1:0] code);
        id_selected = (code == IR_IDCODE);
    endfunction : id_selected

    // Only the two shift states may drive data out
    function automatic logic shifting(input tap_state_t s);
        shifting = (s == ST_SHIFT_DR) || (s == ST_SHIFT_IR);
    endfunction : shifting

    // Data out follows whichever register is being shifted
    function automatic logic tdo_pick(input tap_state_t          s,
                                      input logic [IR_WIDTH-1:0] irs,
                                      input logic [ID_WIDTH-1:0] drs);
        if (s == ST_SHIFT_IR)
            tdo_pick = irs[0];
        else
            tdo_pick = drs[0];
    endfunction : tdo_pick

    // Bypass keeps one bit; the identification register all of them
    function automatic logic [ID_WIDTH-1:0] dr_step(
        input logic [IR_WIDTH-1:0] code,
        input logic [ID_WIDTH-1:0] cur,
        input logic                din
    );
        if (id_selected(code))
            dr_step = {din, cur[ID_WIDTH-1:1]};
        else
            dr_step = {{(ID_WIDTH-1){1'b0}}, din};
    endfunction : dr_step

    // Pin inputs pass two flops; first stage feeds only the second
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            tck_sync  <= 2'h0;
            tms_sync  <= 2'h3;
            tdi_sync  <= 2'h3;
            // Idle high: a low here would fake a port reset
            trst_sync <= 2'h3;
            tck_prev  <= 1'b0;
        end
        else
        begin
            tck_sync  <= {tck_sync[0], link.tck};
            tms_sync  <= {tms_sync[0], link.tms};
            tdi_sync  <= {tdi_sync[0], link.tdi};
            trst_sync <= {trst_sync[0], link.trst_n};
            tck_prev  <= tck_sync[1];
        end
    end

    assign rise    = edge_seen(tck_sync[1], tck_prev);
    assign fall    = edge_seen(tck_prev, tck_sync[1]);
    // The synchronised test reset drops straight into test-logic-reset
    assign tap_rst = ~trst_sync[1];

    always_comb
    begin
        next_state      = state;
        next_ir_shift   = ir_shift;
        next_ir         = ir;
        next_dr_shift   = dr_shift;
        next_tdo_q      = tdo_q;
        next_tdo_oe_n_q = tdo_oe_n_q;
        next_was_reset  = was_reset;
        if (tap_rst)
        begin
            next_state     = ST_RESET;
            next_ir        = IR_RESET;
            next_was_reset = 1'b1;
            // Float data out at once, not at the next fall
            next_tdo_oe_n_q = 1'b1;
        end
        else if (rise)
        begin
            next_state = tap_next(state, tms_sync[1]);
            case (state)
                ST_RESET:
                begin
                    next_ir        = IR_RESET;
                    next_was_reset = 1'b1;
                end
                ST_CAP_IR:
                    next_ir_shift = {{(IR_WIDTH-1){1'b0}}, 1'b1};
                ST_SHIFT_IR:
                    next_ir_shift = {tdi_sync[1],
                                     ir_shift[IR_WIDTH-1:1]};
                ST_UPD_IR:
                    next_ir = ir_shift;
                ST_CAP_DR:
                    next_dr_shift = id_selected(ir) ? ID_VALUE : '0;
                ST_SHIFT_DR:
                    next_dr_shift = dr_step(ir, dr_shift, tdi_sync[1]);
                default:
                    next_ir = ir;
            endcase
        end
        else if (fall)
        begin
            // Apart from the test-reset float, data out moves on the falling edge only
            next_tdo_oe_n_q = ~shifting(state);
            next_tdo_q      = tdo_pick(state, ir_shift, dr_shift);
        end
        // Float FIFO data until the port has seen a reset
        next_float_q    = ~(was_reset | next_was_reset);
        next_in_reset_q = (next_state == ST_RESET);
    end

    // Only the system reset reset_n_i resets the port registers here
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state      <= ST_RESET;
            ir_shift   <= '0;
            ir         <= IR_RESET;
            dr_shift   <= '0;
            tdo_q      <= 1'b0;
            tdo_oe_n_q <= 1'b1;
            was_reset  <= 1'b0;
            float_q    <= 1'b1;
            in_reset_q <= 1'b1;
        end
        else
        begin
            state      <= next_state;
            ir_shift   <= next_ir_shift;
            ir         <= next_ir;
            dr_shift   <= next_dr_shift;
            tdo_q      <= next_tdo_q;
            tdo_oe_n_q <= next_tdo_oe_n_q;
            was_reset  <= next_was_reset;
            float_q    <= next_float_q;
            in_reset_q <= next_in_reset_q;
        end
    end

    assign link.tdo_drv   = tdo_q;
    assign link.tdo_oe_n  = tdo_oe_n_q;
    assign fifo_out_float_o = float_q;
    assign tap_in_reset_o   = in_reset_q;

    // Master reset input is accepted for a shared wiring, unused here
    logic unused_mrs;
    assign unused_mrs = fifo_master_reset_n_i;
endmodule : tap_device

/* tap_controller.sv */
// Purpose: Tester end of the boundary-scan port.
// Assumes: One request at a time; start pulses only while ready.
// Notes:   Divides clk_i to make the test clock.
`timescale 1ns/10ps
module tap_controller
    import tap_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    tap_if.ctrl             link,
    input  wire logic       start_i,
    input  wire logic       tms_i,
    input  wire logic       tdi_i,
    input  wire logic       trst_n_i,
    output logic            ready_o,
    output logic            tdo_o,
    output logic            done_o
);
    logic [7:0] div;
    logic [7:0] next_div;
    logic       busy;
    logic       next_busy;
    logic       tck_q;
    logic       next_tck_q;
    logic       tms_q;
    logic       next_tms_q;
    logic       tdi_q;
    logic       next_tdi_q;
    logic       tdo_q;
    logic       next_tdo_q;
    logic       done_q;
    logic       next_done_q;
    logic       ready_q;
    logic       next_ready_q;
    logic [1:0] tdo_sync;

    // Tester holds mode select for the full cycle, steering the device
    always_comb
    begin
        next_div    = div;
        next_busy   = busy;
        next_tck_q  = tck_q;
        next_tms_q  = tms_q;
        next_tdi_q  = tdi_q;
        next_tdo_q  = tdo_q;
        next_done_q = 1'b0;
        if (!busy)
        begin
            if (start_i)
            begin
                next_busy  = 1'b1;
                next_tms_q = tms_i;
                next_tdi_q = tdi_i;
                next_div   = 8'h00;
            end
        end
        else if (div == 8'(TCK_DIV-1))
        begin
            next_div = 8'h00;
            if (!tck_q)
            begin
                next_tck_q = 1'b1;
                next_tdo_q = tdo_sync[1];
            end
            else
            begin
                next_tck_q  = 1'b0;
                next_busy   = 1'b0;
                next_done_q = 1'b1;
            end
        end
        else
            next_div = div + 8'h01;
        // Registered so the output comes straight from a flop
        next_ready_q = ~next_busy;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            div      <= 8'h00;
            busy     <= 1'b0;
            tck_q    <= 1'b0;
            tms_q    <= 1'b1;
            tdi_q    <= 1'b1;
            tdo_q    <= 1'b0;
            done_q   <= 1'b0;
            ready_q  <= 1'b1;
            tdo_sync <= 2'h0;
        end
        else
        begin
            div      <= next_div;
            busy     <= next_busy;
            tck_q    <= next_tck_q;
            tms_q    <= next_tms_q;
            tdi_q    <= next_tdi_q;
            tdo_q    <= next_tdo_q;
            done_q   <= next_done_q;
            ready_q  <= next_ready_q;
            tdo_sync <= {tdo_sync[0], link.tdo};
        end
    end

    assign link.tck      = tck_q;
    assign link.tms_drv  = tms_q;
    assign link.tms_oe_n = 1'b0;
    assign link.tdi_drv  = tdi_q;
    assign link.tdi_oe_n = 1'b0;
    // Reset by pin or by five high mode-select cycles from the user
    assign link.trst_n   = trst_n_i;
    assign ready_o       = ready_q;
    assign tdo_o         = tdo_q;
    assign done_o        = done_q;
endmodule : tap_controller

/* tap_sva.sv */
// Purpose: Watches the link between the two port ends.
// Assumes: Test clock high for four system clocks per cycle.
// Notes:   Data out is judged on the resolved wire.
`timescale 1ns/10ps
module tap_sva
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic tck,
    input wire logic tms,
    input wire logic tms_oe_n,
    input wire logic tdi,
    input wire logic tdi_oe_n,
    input wire logic trst_n,
    input wire logic tdo,
    input wire logic tdo_oe_n
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    AST_TCK_HIGH: assert property ($rose(tck) |-> tck [*4] ##1 !tck)
        else $error("test clock high phase wrong length");
    AST_TCK_LOW: assert property ($fell(tck) |-> !tck [*4])
        else $error("test clock low phase too short");
    AST_TMS_HELD: assert property ($rose(tck) |-> $stable(tms) [*4])
        else $error("mode select moved around rising edge");
    AST_TDI_HELD: assert property ($rose(tck) |-> $stable(tdi) [*4])
        else $error("data in moved around rising edge");
    AST_TDO_HELD: assert property ($rose(tck) |-> $stable(tdo) [*4])
        else $error("data out moved while test clock high");
    AST_OE_ON_LOW: assert property ($changed(tdo_oe_n) |-> !tck)
        else $error("data out enable moved while test clock high");
    AST_TRST_FLOAT: assert property (!trst_n [*5] |-> tdo_oe_n)
        else $error("data out driven during test reset");
    AST_TDI_PULLUP: assert property (tdi_oe_n |-> tdi)
        else $error("undriven data in not high");
    AST_TMS_PULLUP: assert property (tms_oe_n |-> tms)
        else $error("undriven mode select not high");

    cover property ($fell(tdo_oe_n));
    cover property ($fell(trst_n));
    cover property ($rose(tck) && !tms);
endmodule : tap_sva

/* tb_top.sv */
// Purpose: Drives both port ends through reset, ID, bypass and resets.
// Assumes: One test clock cycle per start pulse.
// Notes:   Captured instruction bits are left unchecked.
`timescale 1ns/10ps
module tb_top
    import tap_pkg::*;
;
    localparam logic [1:0] FLT = 2'b11;
    logic        clk_i     = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        start_i   = 1'b0;
    logic        tms_i     = 1'b1;
    logic        tdi_i     = 1'b1;
    logic        trst_n_i  = 1'b1;
    logic        ready_o;
    logic        tdo_o;
    logic        done_o;
    logic        float_o;
    logic        in_reset_o;
    logic [1:0]  e;
    logic [31:0] d;
    logic [31:0] lfsr      = 32'h26a49678;
    logic [1:0]  exp_q[$];
    int          error_cnt = 0;
    int          checks    = 0;

    tap_if link ();

    always #20 clk_i = ~clk_i;

    tap_device u_tap_device (
        .clk_i                 (clk_i),
        .reset_n_i             (reset_n_i),
        .link                  (link),
        .fifo_master_reset_n_i (trst_n_i),
        .fifo_out_float_o      (float_o),
        .tap_in_reset_o        (in_reset_o)
    );
    tap_controller u_tap_controller (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .link      (link),
        .start_i   (start_i),
        .tms_i     (tms_i),
        .tdi_i     (tdi_i),
        .trst_n_i  (trst_n_i),
        .ready_o   (ready_o),
        .tdo_o     (tdo_o),
        .done_o    (done_o)
    );
    tap_sva u_tap_sva (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .tck       (link.tck),
        .tms       (link.tms),
        .tms_oe_n  (link.tms_oe_n),
        .tdi       (link.tdi),
        .tdi_oe_n  (link.tdi_oe_n),
        .trst_n    (link.trst_n),
        .tdo       (link.tdo),
        .tdo_oe_n  (link.tdo_oe_n)
    );

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic ex, input logic got);
        checks++;
        if (got !== ex)
        begin
            error_cnt++;
            $display("wrong value %s expected %b seen %b", what, ex, got);
        end
    endtask : check

    // Bounded: a stuck handshake ends the run as a mismatch
    task automatic wait_for(input logic on_done);
        int n;
        n = 0;
        while ((on_done ? done_o : ready_o) !== 1'b1)
        begin
            @(negedge clk_i);
            n++;
            if (n > 40)
            begin
                check("handshake", 1'b1, 1'b0);
                conclude();
            end
        end
    endtask : wait_for

    // One test clock cycle; ex = {compare, data out seen at the rise}
    task automatic step(input logic m, input logic t, input logic [1:0] ex);
        wait_for(1'b0);
        start_i = 1'b1;
        tms_i   = m;
        tdi_i   = t;
        exp_q.push_back(ex);
        @(negedge clk_i);
        start_i = 1'b0;
        wait_for(1'b1);
        @(negedge clk_i);
    endtask : step

    // From idle; data out floats (reads high) until shifting starts
    task automatic to_shift(input logic ir);
        step(1'b1, 1'b1, FLT);
        if (ir)
            step(1'b1, 1'b1, FLT);
        step(1'b0, 1'b1, FLT);
        step(1'b0, 1'b1, FLT);
    endtask : to_shift

    task automatic shift(input int n, input logic [31:0] din,
                         input logic [31:0] dout, input logic chk);
        for (int i = 0; i < n; i++)
            step(i == n - 1, din[i], {chk, dout[i]});
        step(1'b1, 1'b1, FLT);
        step(1'b0, 1'b1, FLT);
    endtask : shift

    always @(negedge clk_i)
    begin
        if (done_o === 1'b1)
        begin
            e = exp_q.pop_front();
            if (e[1])
                check("tdo", e[0], tdo_o);
        end
    end

    initial
    begin
        repeat (5) @(negedge clk_i);
        reset_n_i = 1'b1;
        @(negedge clk_i);
        check("fifo float", 1'b1, float_o);
        check("in reset", 1'b1, in_reset_o);
        step(1'b0, 1'b1, FLT);
        check("fifo float", 1'b0, float_o);
        check("in reset", 1'b0, in_reset_o);
        $display("test reset state ended");
        to_shift(1'b0);
        shift(32, rnd(), ID_VALUE, 1'b1);
        $display("test id read ended");
        to_shift(1'b1);
        shift(IR_WIDTH, {28'h0, IR_BYPASS}, 32'h0, 1'b0);
        to_shift(1'b0);
        d = rnd();
        shift(32, d, {d[30:0], 1'b0}, 1'b1);
        $display("test bypass ended");
        to_shift(1'b0);
        step(1'b1, 1'b1, 2'b10);
        repeat (3) step(1'b1, 1'b1, FLT);
        check("in reset", 1'b0, in_reset_o);
        step(1'b1, 1'b1, FLT);
        check("in reset", 1'b1, in_reset_o);
        step(1'b0, 1'b1, FLT);
        to_shift(1'b0);
        shift(32, rnd(), ID_VALUE, 1'b1);
        $display("test five high reset ended");
        to_shift(1'b0);
        trst_n_i = 1'b0;
        repeat (6) @(negedge clk_i);
        check("in reset", 1'b1, in_reset_o);
        check("tdo driven", 1'b0, link.tdo_active);
        trst_n_i = 1'b1;
        @(negedge clk_i);
        step(1'b0, 1'b1, FLT);
        $display("test async reset ended");
        conclude();
    end
endmodule : tb_top
